// ===== ssc_pkg.sv
// Purpose: shared constants and types for one signal supervision channel
// Assumes: values and limits in hundredths, signed 32-bit
// Notes: selector code for torque is a local encoding of the signal table
`default_nettype none
package ssc_pkg;
   localparam int VAL_W = 32;
   localparam int FILT_W = 16;
   localparam int FRAC_W = 16;
   localparam int NUM_SIG = 8;
   localparam int SEL_W = 4;

   // supervision modes
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_LOW = 4'h1;
   localparam logic [3:0] MODE_HIGH = 4'h2;
   localparam logic [3:0] MODE_ABS_LOW = 4'h3;
   localparam logic [3:0] MODE_ABS_HIGH = 4'h4;
   localparam logic [3:0] MODE_BOTH = 4'h5;
   localparam logic [3:0] MODE_ABS_BOTH = 4'h6;
   localparam logic [3:0] MODE_HYST = 4'h7;

   // responses
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_WARN = 2'h1;
   localparam logic [1:0] ACT_FAULT = 2'h2;
   localparam logic [1:0] ACT_FAULT_RUN = 2'h3;

   // event codes reported with warning and trip
   localparam logic [15:0] CODE_WARN = 16'hA8B0;
   localparam logic [15:0] CODE_FAULT = 16'h80B0;

   // reset values and limits of the settings
   localparam logic [SEL_W-1:0] SEL_TORQUE = 4'h3;
   localparam logic [FILT_W-1:0] FILT_RST = 16'h0000;
   localparam logic [FILT_W-1:0] FILT_MAX_MS = 16'h7530; // 30.000 s, 1000 = 1 s
   localparam logic [VAL_W-1:0] LIMIT_RST = 32'h0000_0000;
   localparam logic [VAL_W-1:0] HYST_MAX = 32'h0098_9680; // 100000.00
   localparam logic [VAL_W-1:0] LIMIT_MAX = 32'h7FFF_FD78; // 21474830.00

   // control update period
   localparam int CLK_MHZ = 125;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;

   typedef struct packed {
      logic [3:0] mode;
      logic [1:0] action;
      logic [SEL_W-1:0] sel;
      logic [FILT_W-1:0] filt_ms;
      logic signed [VAL_W-1:0] lo;
      logic signed [VAL_W-1:0] hi;
      logic [VAL_W-1:0] hyst;
   } ssc_cfg_t;

   typedef struct packed {
      logic cond;
      logic warn;
      logic fault;
   } ssc_stat_t;
endpackage : ssc_pkg
`default_nettype wire

// ===== ssc_channel.sv
// Purpose: one signal supervision channel: select, filter, compare, respond
// Assumes: settings arrive as a struct written by cfg_wr; inputs synchronous
// Notes: filter gain is a power-of-two approximation of the time constant
`timescale 1ns/1ps
`default_nettype none
module ssc_channel
   import ssc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   input wire logic clk_sys, // system clock
   input wire logic resetn, // synchronous reset, active low
   input wire logic [NUM_SIG-1:0][VAL_W-1:0] sig_in, // selectable signals
   input wire ssc_cfg_t cfg_in, // new settings
   input wire logic cfg_wr, // take cfg_in, one-cycle pulse
   input wire logic motor_running, // motor is running
   input wire logic fault_reset, // clears a latched trip
   output ssc_stat_t stat_q, // condition, warning, trip
   output logic [15:0] code_q, // active event code, zero when none
   output logic signed [VAL_W-1:0] filt_q // filtered signal
);
   ssc_cfg_t cfg_q, cfg_d;
   logic [$clog2(TICK_CYC)-1:0] tick_cnt_q, tick_cnt_d;
   logic tick_q, tick_d;
   logic signed [VAL_W+FRAC_W-1:0] acc_q, acc_d;
   ssc_stat_t stat_d;
   logic [15:0] code_d;

   logic signed [VAL_W-1:0] sel_val;
   logic signed [VAL_W+FRAC_W:0] diff;
   logic signed [VAL_W+FRAC_W:0] step;
   logic signed [VAL_W+FRAC_W:0] acc_sum;
   logic [4:0] shift;
   logic signed [VAL_W+1:0] x, half, lo_m, lo_p, hi_m, hi_p;
   logic [VAL_W+1:0] ax, alo_m, alo_p, ahi_m, ahi_p;
   logic set_c, clr_c;

   function automatic logic [4:0] log2_floor(input logic [FILT_W:0] v);
      logic [4:0] r;
      r = 5'd0;
      for (int i = 0; i <= FILT_W; i++) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction : log2_floor

   function automatic logic [VAL_W+1:0] mag(input logic signed [VAL_W+1:0] v);
      return v[VAL_W+1] ? (VAL_W+2)'(-v) : v;
   endfunction : mag

   // settings, clamped to their legal ranges on write
   always_comb begin
      cfg_d = cfg_q;
      if (cfg_wr) begin
         cfg_d = cfg_in;
         if (cfg_in.filt_ms > FILT_MAX_MS) begin
            cfg_d.filt_ms = FILT_MAX_MS;
         end
         if (cfg_in.hyst > HYST_MAX) begin
            cfg_d.hyst = HYST_MAX;
         end
         if (cfg_in.lo > $signed(LIMIT_MAX)) begin
            cfg_d.lo = LIMIT_MAX;
         end else if (cfg_in.lo < -$signed(LIMIT_MAX)) begin
            cfg_d.lo = -$signed(LIMIT_MAX);
         end
         if (cfg_in.hi > $signed(LIMIT_MAX)) begin
            cfg_d.hi = LIMIT_MAX;
         end else if (cfg_in.hi < -$signed(LIMIT_MAX)) begin
            cfg_d.hi = -$signed(LIMIT_MAX);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cfg_q.mode <= MODE_OFF;
         cfg_q.action <= ACT_NONE;
         cfg_q.sel <= SEL_TORQUE;
         cfg_q.filt_ms <= FILT_RST;
         cfg_q.lo <= LIMIT_RST;
         cfg_q.hi <= LIMIT_RST;
         cfg_q.hyst <= LIMIT_RST;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // control update tick, one pulse per millisecond
   always_comb begin
      tick_cnt_d = tick_cnt_q + 1'b1;
      tick_d = 1'b0;
      if (tick_cnt_q == ($clog2(TICK_CYC))'(TICK_CYC - 1)) begin
         tick_cnt_d = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_d;
      end
   end

   // signal select; out-of-range selector reads as zero
   always_comb begin
      sel_val = '0;
      if (cfg_q.sel < SEL_W'(NUM_SIG)) begin
         sel_val = sig_in[cfg_q.sel[$clog2(NUM_SIG)-1:0]];
      end
   end

   // first-order low-pass, gain 1/2^k with 2^k near time constant in ticks
   // a shift keeps the filter to one subtractor and one adder; the time constant is coarse
   always_comb begin
      shift = log2_floor({1'b0, cfg_q.filt_ms} + 17'd1);
      diff = {sel_val[VAL_W-1], sel_val, {FRAC_W{1'b0}}} - {acc_q[VAL_W+FRAC_W-1], acc_q};
      step = diff >>> shift;
      acc_sum = {acc_q[VAL_W+FRAC_W-1], acc_q} + step;
      acc_d = acc_q;
      if (tick_q) begin
         acc_d = acc_sum[VAL_W+FRAC_W-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         acc_q <= '0;
         filt_q <= '0;
      end else begin
         acc_q <= acc_d;
         filt_q <= acc_d[VAL_W+FRAC_W-1:FRAC_W];
      end
   end

   // thresholds widened by two bits so limit plus half hysteresis cannot wrap
   always_comb begin
      x = (VAL_W+2)'(filt_q);
      half = (VAL_W+2)'({1'b0, cfg_q.hyst[VAL_W-1:1]});
      lo_m = (VAL_W+2)'(cfg_q.lo) - half;
      lo_p = (VAL_W+2)'(cfg_q.lo) + half;
      hi_m = (VAL_W+2)'(cfg_q.hi) - half;
      hi_p = (VAL_W+2)'(cfg_q.hi) + half;
      ax = mag(x);
      alo_m = mag(lo_m);
      alo_p = mag(lo_p);
      ahi_m = mag(hi_m);
      ahi_p = mag(hi_p);
   end

   // mode comparison: set and clear terms, hold otherwise
   always_comb begin
      set_c = 1'b0;
      clr_c = 1'b0;
      case (cfg_q.mode)
         MODE_LOW: begin
            set_c = x < lo_m;
            clr_c = x > lo_p;
         end
         MODE_HIGH: begin
            set_c = x > hi_p;
            clr_c = x < hi_m;
         end
         MODE_ABS_LOW: begin
            set_c = ax < alo_m;
            clr_c = ax > alo_p;
         end
         MODE_ABS_HIGH: begin
            set_c = ax > ahi_p;
            clr_c = ax < ahi_m;
         end
         MODE_BOTH: begin
            set_c = (x > hi_p) || (x < lo_m);
            clr_c = (x < hi_m) && (x > lo_p);
         end
         MODE_ABS_BOTH: begin
            set_c = (ax > ahi_p) || (ax < alo_m);
            clr_c = (ax < ahi_m) && (ax > alo_p);
         end
         MODE_HYST: begin
            set_c = x > hi_p;
            clr_c = x < lo_m;
         end
         default: begin
            clr_c = 1'b1;
         end
      endcase
   end

   // condition and response; a trip latches until fault_reset, new trip wins
   always_comb begin
      stat_d = stat_q;
      if (tick_q) begin
         if (set_c) begin
            stat_d.cond = 1'b1;
         end else if (clr_c) begin
            stat_d.cond = 1'b0;
         end
      end
      if (cfg_q.mode == MODE_OFF) begin
         stat_d.cond = 1'b0;
      end
      // condition bit is never gated by the action setting; the warning bit is set only under ACT_WARN
      stat_d.warn = stat_d.cond && (cfg_q.action == ACT_WARN);
      if (fault_reset) begin
         stat_d.fault = 1'b0;
      end
      case (cfg_q.action)
         ACT_FAULT: begin
            if (stat_d.cond) begin
               stat_d.fault = 1'b1;
            end
         end
         ACT_FAULT_RUN: begin
            if (stat_d.cond && motor_running) begin
               stat_d.fault = 1'b1;
            end
         end
         default: begin
            stat_d.fault = stat_d.fault;
         end
      endcase
      code_d = 16'h0000;
      if (stat_d.fault) begin
         code_d = CODE_FAULT;
      end else if (stat_d.warn) begin
         code_d = CODE_WARN;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         stat_q <= '0;
         code_q <= 16'h0000;
      end else begin
         stat_q <= stat_d;
         code_q <= code_d;
      end
   end
endmodule : ssc_channel
`default_nettype wire

// ===== ssc_chk.sv
// Purpose: checker for one signal supervision channel
// Assumes: sees only the top module ports
// Notes: shadows mode and action from the settings strobe
`timescale 1ns/1ps
`default_nettype none
module ssc_chk
   import ssc_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic resetn, // synchronous reset, active low
   input wire ssc_cfg_t cfg_in, // new settings
   input wire logic cfg_wr, // settings strobe
   input wire logic motor_running, // motor is running
   input wire logic fault_reset, // trip clear
   input wire ssc_stat_t stat_q, // condition, warning, trip
   input wire logic [15:0] code_q // event code
);
   logic [3:0] mode_q;
   logic [1:0] act_q;
   // shadow settings, so responses can be tied to the action in force
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         mode_q <= MODE_OFF;
         act_q <= ACT_NONE;
      end else if (cfg_wr) begin
         mode_q <= cfg_in.mode;
         act_q <= cfg_in.action;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // outputs seen at an edge come from inputs of the edge before
   property p_none; $past(act_q) == ACT_NONE && !$past(stat_q.fault) |-> !stat_q.warn && !stat_q.fault; endproperty
   a_none: assert property (p_none) else $error("response with no action");
   property p_warn; $past(act_q) == ACT_WARN |-> stat_q.warn == stat_q.cond; endproperty
   a_warn: assert property (p_warn) else $error("warning not following condition");
   property p_trip; $past(act_q) == ACT_FAULT && stat_q.cond |-> stat_q.fault; endproperty
   a_trip: assert property (p_trip) else $error("no trip on condition");
   property p_run; $past(act_q) == ACT_FAULT_RUN && $past(motor_running) && stat_q.cond |-> stat_q.fault; endproperty
   a_run: assert property (p_run) else $error("no trip while running");
   property p_idle; $past(act_q) == ACT_FAULT_RUN && !$past(motor_running) && !$past(stat_q.fault) |-> !stat_q.fault; endproperty
   a_idle: assert property (p_idle) else $error("trip while stopped");
   property p_code; code_q == (stat_q.fault ? CODE_FAULT : (stat_q.warn ? CODE_WARN : 16'h0000)); endproperty
   a_code: assert property (p_code) else $error("event code mismatch");
   property p_off; mode_q == MODE_OFF |=> !stat_q.cond; endproperty
   a_off: assert property (p_off) else $error("condition in off mode");
   property p_latch; $past(stat_q.fault) && !$past(fault_reset) |-> stat_q.fault; endproperty
   a_latch: assert property (p_latch) else $error("trip dropped without clear");
   c_warn: cover property (stat_q.warn);
   c_run: cover property (stat_q.fault && $past(act_q) == ACT_FAULT_RUN);
   c_clear: cover property ($fell(stat_q.fault));
endmodule : ssc_chk
bind ssc_channel ssc_chk ssc_chk_i (.clk_sys, .resetn, .cfg_in, .cfg_wr, .motor_running,
   .fault_reset, .stat_q, .code_q);
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench for one supervision channel
// Assumes: short update period; limits -1.00/+1.00, hysteresis 0.20
// Notes: table rows first, awkward cases after
`timescale 1ns/1ps
`default_nettype none
module testbench
   import ssc_pkg::*;
;
   localparam int TCYC = 10;
   localparam logic signed [31:0] H = 32'sh0000_0064;
   typedef struct packed {
      logic [3:0] mode;
      logic [1:0] act;
      logic signed [31:0] sig;
      logic run;
      ssc_stat_t exp;
   } ssc_row_t;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [NUM_SIG-1:0][VAL_W-1:0] sig_in = '0;
   ssc_cfg_t cfg_in = '0;
   logic cfg_wr = 1'b0;
   logic motor_running = 1'b0;
   logic fault_reset = 1'b0;
   ssc_stat_t stat_q;
   logic [15:0] code_q;
   logic signed [VAL_W-1:0] filt_q;
   int error_cnt = 0;
   int n_compared = 0;
   int cyc = 0;
   // mode, action, signal, running, expected {cond, warn, fault}
   ssc_row_t rows [15] = '{'{4'h0, 2'h1, -5*H, 1'b0, 3'b000}, '{4'h1, 2'h0, -2*H, 1'b0, 3'b100},
      '{4'h1, 2'h1, -H-H/20, 1'b0, 3'b000}, '{4'h2, 2'h1, H+H/9, 1'b0, 3'b110},
      '{4'h2, 2'h2, H+H/20, 1'b0, 3'b000}, '{4'h2, 2'h2, 2*H, 1'b0, 3'b101},
      '{4'h2, 2'h3, 2*H, 1'b0, 3'b100}, '{4'h2, 2'h3, 2*H, 1'b1, 3'b101},
      '{4'h3, 2'h1, -H/2, 1'b0, 3'b110}, '{4'h3, 2'h1, -2*H, 1'b0, 3'b000},
      '{4'h5, 2'h1, -2*H, 1'b0, 3'b110}, '{4'h5, 2'h1, 2*H, 1'b0, 3'b110},
      '{4'h7, 2'h1, 2*H, 1'b0, 3'b110}, '{4'h4, 2'h1, -2*H, 1'b0, 3'b110},
      '{4'h6, 2'h1, -H/2, 1'b0, 3'b110}};
   ssc_channel #(.TICK_CYC(TCYC)) ssc_channel_i (.clk_sys, .resetn, .sig_in, .cfg_in, .cfg_wr,
      .motor_running, .fault_reset, .stat_q, .code_q, .filt_q);
   // 125 MHz
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic final_report;
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   // hang guard, well above the expected run length
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         final_report;
      end
   end
   task automatic chk_stat(input ssc_stat_t e);
      n_compared++;
      if (stat_q !== e) begin
         error_cnt++;
         $display("Error at %0t: status %b, expected %b", $time, stat_q, e);
      end
   endtask : chk_stat
   task automatic chk_val(input logic [31:0] got, input logic [31:0] e);
      n_compared++;
      if (got !== e) begin
         error_cnt++;
         $display("Error at %0t: value %h, expected %h", $time, got, e);
      end
   endtask : chk_val
   function automatic logic [31:0] exp_code(input ssc_stat_t s);
      return s.fault ? CODE_FAULT : (s.warn ? CODE_WARN : 16'h0000);
   endfunction : exp_code
   // two reset edges, so no state leaks between cases
   task automatic rst;
      @(negedge clk_sys);
      resetn = 1'b0;
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
   endtask : rst
   task automatic cfg(input logic [3:0] m, input logic [1:0] a, input logic [15:0] f);
      @(negedge clk_sys);
      cfg_in = '{mode: m, action: a, sel: SEL_TORQUE, filt_ms: f, lo: -H, hi: H, hyst: H/5};
      cfg_wr = 1'b1;
      @(negedge clk_sys);
      cfg_wr = 1'b0;
   endtask : cfg
   // unselected inputs carry the mirror value as a decoy
   task automatic drive(input logic signed [31:0] v, input logic r);
      @(negedge clk_sys);
      for (int i = 0; i < NUM_SIG; i++)
         sig_in[i] = -v;
      sig_in[SEL_TORQUE] = v;
      motor_running = r;
      repeat (4 * TCYC) @(negedge clk_sys);
   endtask : drive
   initial begin
      repeat (16) @(negedge clk_sys);
      chk_stat(3'b000);
      chk_val({16'h0000, code_q}, 32'h0000_0000);
      chk_val(filt_q, 32'h0000_0000);
      resetn = 1'b1;
      foreach (rows[i]) begin
         rst;
         cfg(rows[i].mode, rows[i].act, 16'h0000);
         drive(rows[i].sig, rows[i].run);
         chk_stat(rows[i].exp);
         chk_val({16'h0000, code_q}, exp_code(rows[i].exp));
         chk_val(filt_q, rows[i].sig);
      end
      // hold between the bands
      rst;
      cfg(MODE_HYST, ACT_WARN, 16'h0000);
      drive(2*H, 1'b0);
      drive(16'h0000, 1'b0);
      chk_stat(3'b110);
      drive(-2*H, 1'b0);
      chk_stat(3'b000);
      // trip stays after the condition goes, until cleared
      cfg(MODE_HIGH, ACT_FAULT, 16'h0000);
      drive(2*H, 1'b0);
      drive(16'h0000, 1'b0);
      chk_stat(3'b001);
      chk_val({16'h0000, code_q}, CODE_FAULT);
      @(negedge clk_sys);
      fault_reset = 1'b1;
      @(negedge clk_sys);
      fault_reset = 1'b0;
      chk_stat(3'b000);
      // action change leaves the status bit alone
      cfg(MODE_HIGH, ACT_WARN, 16'h0000);
      drive(2*H, 1'b0);
      cfg(MODE_HIGH, ACT_NONE, 16'h0000);
      drive(2*H, 1'b0);
      chk_stat(3'b100);
      // defaults after reset: torque selected, no filtering
      rst;
      drive(H, 1'b0);
      chk_val(filt_q, H);
      // an upper limit past the legal range is clamped on write
      @(negedge clk_sys);
      cfg_in = '{mode: MODE_HIGH, action: ACT_WARN, sel: SEL_TORQUE, filt_ms: 16'h0000,
         lo: -H, hi: 32'sh7FFF_FFFF, hyst: 32'h0000_0000};
      cfg_wr = 1'b1;
      @(negedge clk_sys);
      cfg_wr = 1'b0;
      drive(32'sh7FFF_FD80, 1'b0);
      chk_stat(3'b110);
      // a long time constant leaves the output short of the step
      rst;
      cfg(MODE_OFF, ACT_NONE, 16'h03E8);
      drive(2*H, 1'b0);
      chk_val(filt_q > 0 && filt_q < 2*H, 32'h0000_0001);
      final_report;
   end
endmodule : testbench
`default_nettype wire
